// ---- rtl/prl_regs.vh ----
// register offsets, bit masks, field codes and reset values of the priority level block
`ifndef PRL_REGS_VH
`define PRL_REGS_VH

// ----------------------------------------------------------------------
// register indexes; byte address is four times the index
// ----------------------------------------------------------------------
`define PRL_IDX_SEVEN 8'h07
`define PRL_IDX_EIGHT 8'h08
`define PRL_IDX_NINE 8'h09
`define PRL_IDX_STATUS 8'h20
`define PRL_ADDR_W 8

// ----------------------------------------------------------------------
// implemented bit masks and reset values
// ----------------------------------------------------------------------
`define PRL_SEVEN_MASK 16'h0003
`define PRL_EIGHT_MASK 16'hf3ff
`define PRL_NINE_MASK 16'hffff
`define PRL_REG_RESET 16'h0000

// ----------------------------------------------------------------------
// field codes and bus responses
// ----------------------------------------------------------------------
`define PRL_CODE_MASKED 2'h0
`define PRL_CODE_LVL0 2'h1
`define PRL_CODE_LVL1 2'h2
`define PRL_CODE_LVL2 2'h3
`define PRL_RESP_OKAY 2'h0
`define PRL_RESP_SLVERR 2'h2
`define PRL_NUM_SRC 16

`endif

// ---- rtl/prl_level_decode.v ----
// decode of one two-bit priority field into a one-hot level request
`timescale 1ns/1ps
`default_nettype none
`include "prl_regs.vh"

module prl_level_decode (
    input wire [1:0] field_i,
    input wire req_i,
    output reg [2:0] lvl_req_o
);

// ----------------------------------------------------------------------
// field decode
// ----------------------------------------------------------------------
// masked code drops the request, other codes map to levels 0..2 only
always @* begin
    lvl_req_o = 3'h0;
    case (field_i)
        `PRL_CODE_LVL0: lvl_req_o = {2'h0, req_i};
        `PRL_CODE_LVL1: lvl_req_o = {1'h0, req_i, 1'h0};
        `PRL_CODE_LVL2: lvl_req_o = {req_i, 2'h0};
        default: lvl_req_o = 3'h0;
    endcase
end

endmodule // prl_level_decode
`default_nettype wire

// ---- rtl/prl_top.v ----
// priority level registers, axi4-lite slave and level arbitration
//
// The AXI4-Lite interface to the registers was decided locally.
`timescale 1ns/1ps
`default_nettype none
`include "prl_regs.vh"

module prl_top (
    input wire clk_i,
    input wire rst_n_i,
    // axi4-lite write address
    input wire s_axi_awvalid,
    output reg s_axi_awready,
    input wire [31:0] s_axi_awaddr,
    input wire [2:0] s_axi_awprot,
    // axi4-lite write data
    input wire s_axi_wvalid,
    output reg s_axi_wready,
    input wire [31:0] s_axi_wdata,
    input wire [3:0] s_axi_wstrb,
    // axi4-lite write response
    output reg s_axi_bvalid,
    input wire s_axi_bready,
    output reg [1:0] s_axi_bresp,
    // axi4-lite read address
    input wire s_axi_arvalid,
    output reg s_axi_arready,
    input wire [31:0] s_axi_araddr,
    input wire [2:0] s_axi_arprot,
    // axi4-lite read data
    output reg s_axi_rvalid,
    input wire s_axi_rready,
    output reg [31:0] s_axi_rdata,
    output reg [1:0] s_axi_rresp,
    // peripheral request levels
    input wire timer_c_ch1_req_i,
    input wire timer_a_ch1_req_i,
    input wire timer_a_ch2_req_i,
    input wire timer_a_ch3_req_i,
    input wire serial0_tx_empty_req_i,
    input wire serial0_tx_idle_req_i,
    input wire serial0_rx_error_req_i,
    input wire serial0_rx_full_req_i,
    input wire conv_second_complete_req_i,
    input wire conv_first_complete_req_i,
    input wire conv_second_zero_limit_req_i,
    input wire conv_first_zero_limit_req_i,
    input wire pwm_second_reload_req_i,
    input wire pwm_first_reload_req_i,
    input wire pwm_second_fault_req_i,
    input wire pwm_first_fault_req_i,
    // arbitration result towards the core
    output reg irq_valid_o,
    output reg [3:0] irq_source_o,
    output reg [1:0] irq_level_o,
    output reg [2:0] level_active_o
);

// ----------------------------------------------------------------------
// reset release
// ----------------------------------------------------------------------
reg rst_meta_reg;
reg rst_sync_reg;
wire rst_n;

// asynchronous assert, release after two edges
always @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
        rst_meta_reg <= 1'b0;
        rst_sync_reg <= 1'b0;
    end else begin
        rst_meta_reg <= 1'b1;
        rst_sync_reg <= rst_meta_reg;
    end
end

assign rst_n = rst_sync_reg;

// ----------------------------------------------------------------------
// priority registers
// ----------------------------------------------------------------------
reg [15:0] source_priority_reg_seven;
reg [15:0] source_priority_reg_eight;
reg [15:0] source_priority_reg_nine;
reg [15:0] active_req_reg;

// write channel capture
reg aw_full_reg;
reg w_full_reg;
reg [`PRL_ADDR_W-1:0] aw_idx_reg;
reg [15:0] w_data_reg;
reg [1:0] w_strb_reg;
reg aw_full_next;
reg w_full_next;
reg bvalid_next;
reg do_write;

wire [`PRL_ADDR_W-1:0] aw_idx_in;
wire [`PRL_ADDR_W-1:0] ar_idx_in;
wire aw_aligned;
wire ar_aligned;

// word index from byte address; upper bits must be zero to hit
assign aw_idx_in = s_axi_awaddr[`PRL_ADDR_W+1:2];
assign ar_idx_in = s_axi_araddr[`PRL_ADDR_W+1:2];
assign aw_aligned = (s_axi_awaddr[31:`PRL_ADDR_W+2] == 22'h0) && (s_axi_awaddr[1:0] == 2'h0);
assign ar_aligned = (s_axi_araddr[31:`PRL_ADDR_W+2] == 22'h0) && (s_axi_araddr[1:0] == 2'h0);

// channel items taken on this edge
wire aw_take = s_axi_awvalid && s_axi_awready;
wire w_take = s_axi_wvalid && s_axi_wready;
reg aw_hit_reg;

// write handshake next state
always @* begin
    aw_full_next = aw_full_reg;
    w_full_next = w_full_reg;
    bvalid_next = s_axi_bvalid;
    do_write = 1'b0;
    if (aw_take) begin
        aw_full_next = 1'b1;
    end
    if (w_take) begin
        w_full_next = 1'b1;
    end
    if (s_axi_bvalid && s_axi_bready) begin
        bvalid_next = 1'b0;
    end
    if (aw_full_reg && w_full_reg && !s_axi_bvalid) begin
        do_write = 1'b1;
        aw_full_next = 1'b0;
        w_full_next = 1'b0;
        bvalid_next = 1'b1;
    end
end

// address and data hold, ready flags, response
always @(posedge clk_i or negedge rst_n) begin
    if (!rst_n) begin
        aw_full_reg <= 1'b0;
        w_full_reg <= 1'b0;
        aw_idx_reg <= 8'h00;
        aw_hit_reg <= 1'b0;
        w_data_reg <= 16'h0000;
        w_strb_reg <= 2'h0;
        s_axi_awready <= 1'b0;
        s_axi_wready <= 1'b0;
        s_axi_bvalid <= 1'b0;
        s_axi_bresp <= `PRL_RESP_OKAY;
    end else begin
        aw_full_reg <= aw_full_next;
        w_full_reg <= w_full_next;
        s_axi_awready <= !aw_full_next;
        s_axi_wready <= !w_full_next;
        s_axi_bvalid <= bvalid_next;
        if (aw_take) begin
            aw_idx_reg <= aw_idx_in;
            aw_hit_reg <= aw_aligned;
        end
        if (w_take) begin
            w_data_reg <= s_axi_wdata[15:0];
            w_strb_reg <= s_axi_wstrb[1:0];
        end
        if (do_write) begin
            if (aw_hit_reg && (aw_idx_reg == `PRL_IDX_SEVEN || aw_idx_reg == `PRL_IDX_EIGHT
                || aw_idx_reg == `PRL_IDX_NINE || aw_idx_reg == `PRL_IDX_STATUS)) begin
                s_axi_bresp <= `PRL_RESP_OKAY;
            end else begin
                s_axi_bresp <= `PRL_RESP_SLVERR;
            end
        end
    end
end

// byte-lane merge of write data into a register image
function [15:0] prl_merge;
    input [15:0] old_val;
    input [15:0] new_val;
    input [1:0] strb;
    input [15:0] mask;
    reg [15:0] merged;
    begin
        merged = old_val;
        if (strb[0]) begin
            merged[7:0] = new_val[7:0];
        end
        if (strb[1]) begin
            merged[15:8] = new_val[15:8];
        end
        prl_merge = merged & mask;
    end
endfunction

// field storage; unimplemented bits never store a one
always @(posedge clk_i or negedge rst_n) begin
    if (!rst_n) begin
        source_priority_reg_seven <= `PRL_REG_RESET;
        source_priority_reg_eight <= `PRL_REG_RESET;
        source_priority_reg_nine <= `PRL_REG_RESET;
    end else if (do_write && aw_hit_reg) begin
        if (aw_idx_reg == `PRL_IDX_SEVEN) begin
            source_priority_reg_seven <= prl_merge(source_priority_reg_seven, w_data_reg, w_strb_reg,
                `PRL_SEVEN_MASK);
        end
        if (aw_idx_reg == `PRL_IDX_EIGHT) begin
            source_priority_reg_eight <= prl_merge(source_priority_reg_eight, w_data_reg, w_strb_reg,
                `PRL_EIGHT_MASK);
        end
        if (aw_idx_reg == `PRL_IDX_NINE) begin
            source_priority_reg_nine <= prl_merge(source_priority_reg_nine, w_data_reg, w_strb_reg,
                `PRL_NINE_MASK);
        end
    end
end

// ----------------------------------------------------------------------
// read channel
// ----------------------------------------------------------------------
reg [31:0] rd_word;
reg rd_hit;

// read decode; reserved bits come back as zero
always @* begin
    rd_word = 32'h0000_0000;
    rd_hit = ar_aligned;
    case (ar_idx_in)
        `PRL_IDX_SEVEN: rd_word = {16'h0000, source_priority_reg_seven};
        `PRL_IDX_EIGHT: rd_word = {16'h0000, source_priority_reg_eight};
        `PRL_IDX_NINE: rd_word = {16'h0000, source_priority_reg_nine};
        `PRL_IDX_STATUS: rd_word = {16'h0000, active_req_reg};
        default: rd_hit = 1'b0;
    endcase
end

wire ar_take = s_axi_arvalid && s_axi_arready;

// one read at a time, answer one cycle after the address is taken
always @(posedge clk_i or negedge rst_n) begin
    if (!rst_n) begin
        s_axi_arready <= 1'b0;
        s_axi_rvalid <= 1'b0;
        s_axi_rdata <= 32'h0000_0000;
        s_axi_rresp <= `PRL_RESP_OKAY;
    end else begin
        if (ar_take) begin
            s_axi_arready <= 1'b0;
            s_axi_rvalid <= 1'b1;
            s_axi_rdata <= rd_hit ? rd_word : 32'h0000_0000;
            s_axi_rresp <= rd_hit ? `PRL_RESP_OKAY : `PRL_RESP_SLVERR;
        end else if (s_axi_rvalid && s_axi_rready) begin
            s_axi_rvalid <= 1'b0;
            s_axi_arready <= 1'b1;
        end else if (!s_axi_rvalid) begin
            s_axi_arready <= 1'b1;
        end
    end
end

// ----------------------------------------------------------------------
// field extraction per source
// ----------------------------------------------------------------------
// field positions inside the three registers
wire [1:0] timer_c_ch1_level = source_priority_reg_seven[1:0];
wire [1:0] timer_a_ch1_level = source_priority_reg_eight[1:0];
wire [1:0] timer_a_ch2_level = source_priority_reg_eight[3:2];
wire [1:0] timer_a_ch3_level = source_priority_reg_eight[5:4];
wire [1:0] serial0_tx_empty_level = source_priority_reg_eight[7:6];
wire [1:0] serial0_tx_idle_level = source_priority_reg_eight[9:8];
wire [1:0] serial0_rx_error_level = source_priority_reg_eight[13:12];
wire [1:0] serial0_rx_full_level = source_priority_reg_eight[15:14];
wire [1:0] conv_second_complete_level = source_priority_reg_nine[1:0];
wire [1:0] conv_first_complete_level = source_priority_reg_nine[3:2];
wire [1:0] conv_second_zero_limit_level = source_priority_reg_nine[5:4];
wire [1:0] conv_first_zero_limit_level = source_priority_reg_nine[7:6];
wire [1:0] pwm_second_reload_level = source_priority_reg_nine[9:8];
wire [1:0] pwm_first_reload_level = source_priority_reg_nine[11:10];
wire [1:0] pwm_second_fault_level = source_priority_reg_nine[13:12];
wire [1:0] pwm_first_fault_level = source_priority_reg_nine[15:14];

wire [31:0] field_vec;
wire [15:0] req_vec;

// source n uses field_vec[2n+1:2n] and req_vec[n]
assign field_vec = {pwm_first_fault_level, pwm_second_fault_level, pwm_first_reload_level,
    pwm_second_reload_level, conv_first_zero_limit_level, conv_second_zero_limit_level,
    conv_first_complete_level, conv_second_complete_level, serial0_rx_full_level,
    serial0_rx_error_level, serial0_tx_idle_level, serial0_tx_empty_level,
    timer_a_ch3_level, timer_a_ch2_level, timer_a_ch1_level, timer_c_ch1_level};
assign req_vec = {pwm_first_fault_req_i, pwm_second_fault_req_i, pwm_first_reload_req_i,
    pwm_second_reload_req_i, conv_first_zero_limit_req_i, conv_second_zero_limit_req_i,
    conv_first_complete_req_i, conv_second_complete_req_i, serial0_rx_full_req_i,
    serial0_rx_error_req_i, serial0_tx_idle_req_i, serial0_tx_empty_req_i,
    timer_a_ch3_req_i, timer_a_ch2_req_i, timer_a_ch1_req_i, timer_c_ch1_req_i};

// ----------------------------------------------------------------------
// level decode per source
// ----------------------------------------------------------------------
wire [47:0] lvl_vec;

genvar gi;
generate
    for (gi = 0; gi < `PRL_NUM_SRC; gi = gi + 1) begin : g_dec
        prl_level_decode u_dec (
            .field_i(field_vec[2*gi+1:2*gi]),
            .req_i(req_vec[gi]),
            .lvl_req_o(lvl_vec[3*gi+2:3*gi])
        );
    end
endgenerate

// ----------------------------------------------------------------------
// arbitration
// ----------------------------------------------------------------------
reg [15:0] on_lvl0;
reg [15:0] on_lvl1;
reg [15:0] on_lvl2;
reg [15:0] win_set;
reg [3:0] win_src;
reg [1:0] win_lvl;
reg win_found;
integer si;

// highest level first, lowest source number within a level
always @* begin
    on_lvl0 = 16'h0000;
    on_lvl1 = 16'h0000;
    on_lvl2 = 16'h0000;
    win_src = 4'h0;
    win_found = 1'b0;
    for (si = 0; si < `PRL_NUM_SRC; si = si + 1) begin
        on_lvl0[si] = lvl_vec[3*si];
        on_lvl1[si] = lvl_vec[3*si+1];
        on_lvl2[si] = lvl_vec[3*si+2];
    end
    if (on_lvl2 != 16'h0000) begin
        win_set = on_lvl2;
        win_lvl = 2'h2;
    end else if (on_lvl1 != 16'h0000) begin
        win_set = on_lvl1;
        win_lvl = 2'h1;
    end else begin
        win_set = on_lvl0;
        win_lvl = 2'h0;
    end
    for (si = `PRL_NUM_SRC - 1; si >= 0; si = si - 1) begin
        if (win_set[si]) begin
            win_src = si[3:0];
            win_found = 1'b1;
        end
    end
end

// registered result, one cycle behind requests and field writes
always @(posedge clk_i or negedge rst_n) begin
    if (!rst_n) begin
        irq_valid_o <= 1'b0;
        irq_source_o <= 4'h0;
        irq_level_o <= 2'h0;
        level_active_o <= 3'h0;
        active_req_reg <= 16'h0000;
    end else begin
        irq_valid_o <= win_found;
        irq_source_o <= win_found ? win_src : 4'h0;
        irq_level_o <= win_found ? win_lvl : 2'h0;
        level_active_o <= {|on_lvl2, |on_lvl1, |on_lvl0};
        active_req_reg <= on_lvl0 | on_lvl1 | on_lvl2;
    end
end

endmodule // prl_top
`default_nettype wire

// ---- tb/prl_top_sva.sv ----
// checker of the priority level block ports
`timescale 1ns/1ps
`default_nettype none
`include "prl_regs.vh"

module prl_top_sva (
    input wire logic clk_i,
    input wire logic rst_n_i,
    input wire logic s_axi_awvalid,
    input wire logic s_axi_awready,
    input wire logic s_axi_wvalid,
    input wire logic s_axi_wready,
    input wire logic s_axi_bvalid,
    input wire logic s_axi_bready,
    input wire logic s_axi_arvalid,
    input wire logic s_axi_arready,
    input wire logic [31:0] s_axi_araddr,
    input wire logic s_axi_rvalid,
    input wire logic s_axi_rready,
    input wire logic [31:0] s_axi_rdata,
    input wire logic irq_valid_o,
    input wire logic [3:0] irq_source_o,
    input wire logic [1:0] irq_level_o,
    input wire logic [2:0] level_active_o
);
    logic [31:0] rd_addr_reg;
    logic wrote_reg;

    // address of the read in flight, and whether any write has completed
    always_ff @(posedge clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            rd_addr_reg <= 32'h0;
            wrote_reg <= 1'b0;
        end else begin
            if (s_axi_arvalid && s_axi_arready) rd_addr_reg <= s_axi_araddr;
            if (s_axi_bvalid && s_axi_bready) wrote_reg <= 1'b1;
        end
    end

    default clocking cb @(posedge clk_i);
    endclocking
    default disable iff (!rst_n_i);

    // ----
    // bus steps
    // ----
    sequence s_wr_taken;
        s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready;
    endsequence
    sequence s_rd_taken;
        s_axi_arvalid && s_axi_arready;
    endsequence
    property p_wr_answer;
        s_wr_taken |-> ##[1:3] s_axi_bvalid;
    endproperty
    a_wr_answer: assert property (p_wr_answer)
        else $error("write answer late");
    property p_rd_answer;
        s_rd_taken |=> s_axi_rvalid;
    endproperty
    a_rd_answer: assert property (p_rd_answer)
        else $error("read answer late");
    property p_r_hold;
        s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid && $stable(s_axi_rdata);
    endproperty
    a_r_hold: assert property (p_r_hold)
        else $error("read data dropped");
    property p_rsv_eight;
        s_axi_rvalid && rd_addr_reg == {22'h0, `PRL_IDX_EIGHT, 2'b00} |-> s_axi_rdata[31:16] == 16'h0
            && s_axi_rdata[11:10] == 2'b00;
    endproperty
    a_rsv_eight: assert property (p_rsv_eight)
        else $error("reserved bits of register eight set");
    property p_rsv_seven;
        s_axi_rvalid && rd_addr_reg == {22'h0, `PRL_IDX_SEVEN, 2'b00} |-> s_axi_rdata[31:2] == 30'h0;
    endproperty
    a_rsv_seven: assert property (p_rsv_seven)
        else $error("register seven holds more than one field");

    // ----
    // arbitration result
    // ----
    property p_lvl_max;
        irq_level_o != 2'h3;
    endproperty
    a_lvl_max: assert property (p_lvl_max)
        else $error("level above two");
    property p_lvl_top;
        irq_valid_o |-> (level_active_o >> irq_level_o) == 3'h1;
    endproperty
    a_lvl_top: assert property (p_lvl_top)
        else $error("winner not at highest active level");
    property p_idle;
        !irq_valid_o |-> level_active_o == 3'h0 && irq_source_o == 4'h0 && irq_level_o == 2'h0;
    endproperty
    a_idle: assert property (p_idle)
        else $error("idle result not zero");
    property p_reset_masked;
        !wrote_reg |-> !irq_valid_o;
    endproperty
    a_reset_masked: assert property (p_reset_masked)
        else $error("request forwarded before any level set");
endmodule // prl_top_sva

bind prl_top prl_top_sva i_sva (.*);

`default_nettype wire

// ---- tb/prl_src_model.sv ----
// peripheral request sources feeding the sixteen request levels
`timescale 1ns/1ps
`default_nettype none

module prl_src_model (
    input wire logic clk_i,
    input wire logic rst_n_i,
    input wire logic [15:0] want_i,
    input wire logic [1:0] lag_i,
    output logic [15:0] req_o
);
    logic [15:0] pipe_reg [0:2];

    // level requests, answered after one to three cycles
    always_ff @(posedge clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            for (int i = 0; i < 3; i++) pipe_reg[i] <= 16'h0;
        end else begin
            pipe_reg[0] <= want_i;
            pipe_reg[1] <= pipe_reg[0];
            pipe_reg[2] <= pipe_reg[1];
        end
    end
    assign req_o = pipe_reg[lag_i];
endmodule // prl_src_model

`default_nettype wire

// ---- tb/tb_top.sv ----
// self-checking bench of the priority level block
`timescale 1ns/1ps
`default_nettype none
`include "prl_regs.vh"

// compare and count
`define CHK(g, e) begin \
    samples_checked++; \
    if ((g) !== (e)) begin \
        failures++; \
        $display("mismatch %0t got %h want %h", $time, (g), (e)); \
    end \
end

module tb_top;
    localparam logic [31:0] A7 = {22'h0, `PRL_IDX_SEVEN, 2'b00};
    localparam logic [31:0] A8 = {22'h0, `PRL_IDX_EIGHT, 2'b00};
    localparam logic [31:0] A9 = {22'h0, `PRL_IDX_NINE, 2'b00};
    localparam logic [31:0] AST = {22'h0, `PRL_IDX_STATUS, 2'b00};
    logic clk_i = 1'b0;
    logic rst_n_i = 1'b0;
    logic s_axi_awvalid = 1'b0, s_axi_wvalid = 1'b0, s_axi_bready = 1'b0, s_axi_arvalid = 1'b0, s_axi_rready = 1'b0;
    logic [31:0] s_axi_awaddr = 32'h0, s_axi_wdata = 32'h0, s_axi_araddr = 32'h0;
    logic [3:0] s_axi_wstrb = 4'h0;
    logic [2:0] s_axi_awprot = 3'h0, s_axi_arprot = 3'h0;
    wire s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid, irq_valid_o;
    wire [1:0] s_axi_bresp, s_axi_rresp, irq_level_o;
    wire [31:0] s_axi_rdata;
    wire [3:0] irq_source_o;
    wire [2:0] level_active_o;
    wire timer_c_ch1_req_i, timer_a_ch1_req_i, timer_a_ch2_req_i, timer_a_ch3_req_i;
    wire serial0_tx_empty_req_i, serial0_tx_idle_req_i, serial0_rx_error_req_i, serial0_rx_full_req_i;
    wire conv_second_complete_req_i, conv_first_complete_req_i, conv_second_zero_limit_req_i;
    wire conv_first_zero_limit_req_i, pwm_second_reload_req_i, pwm_first_reload_req_i;
    wire pwm_second_fault_req_i, pwm_first_fault_req_i;
    wire [15:0] req;
    logic [15:0] want = 16'h0;
    logic [1:0] lag = 2'h0;
    logic look = 1'b0;
    logic [33:0] exp_q [$];
    logic [33:0] nx;
    logic [31:0] ad [0:2] = '{A7, A8, A9};
    logic [15:0] msk [0:2] = '{`PRL_SEVEN_MASK, `PRL_EIGHT_MASK, `PRL_NINE_MASK};
    logic [15:0] cur [0:2] = '{16'h0, 16'h0, 16'h0};
    int failures = 0;
    int samples_checked = 0;
    int cyc = 0;

    // source n drives request bit n
    assign {pwm_first_fault_req_i, pwm_second_fault_req_i, pwm_first_reload_req_i, pwm_second_reload_req_i,
        conv_first_zero_limit_req_i, conv_second_zero_limit_req_i, conv_first_complete_req_i,
        conv_second_complete_req_i, serial0_rx_full_req_i, serial0_rx_error_req_i, serial0_tx_idle_req_i,
        serial0_tx_empty_req_i, timer_a_ch3_req_i, timer_a_ch2_req_i, timer_a_ch1_req_i, timer_c_ch1_req_i} = req;

    prl_top i_dut (.*);
    prl_src_model i_src (.clk_i(clk_i), .rst_n_i(rst_n_i), .want_i(want), .lag_i(lag), .req_o(req));

    // clock
    initial begin
        forever #4 clk_i = ~clk_i;
    end

    // ----
    // expectations
    // ----
    function automatic logic [33:0] exp_irq(input logic [31:0] fv, input logic [15:0] rq);
        logic [2:0] la;
        logic v;
        logic [3:0] src;
        logic [1:0] lv;
        logic [1:0] c;
        la = 3'h0;
        v = 1'b0;
        src = 4'h0;
        lv = 2'h0;
        for (int n = 0; n < 16; n++) begin
            c = fv[2*n +: 2];
            if (rq[n] && c != `PRL_CODE_MASKED) begin
                la[c - 2'h1] = 1'b1;
                if (!v || c - 2'h1 > lv) begin
                    v = 1'b1;
                    src = n[3:0];
                    lv = c - 2'h1;
                end
            end
        end
        return {24'h0, v, src, lv, la};
    endfunction

    function automatic logic [15:0] enabled(input logic [31:0] fv);
        for (int n = 0; n < 16; n++) enabled[n] = fv[2*n +: 2] != `PRL_CODE_MASKED;
    endfunction

    // ----
    // bus master and sources
    // ----
    task automatic wr(input logic [31:0] a, input logic [31:0] d, input logic [3:0] s, input logic [1:0] r);
        exp_q.push_back({r, 32'h0});
        @(posedge clk_i);
        s_axi_awvalid <= 1'b1;
        s_axi_awaddr <= a;
        s_axi_wvalid <= 1'b1;
        s_axi_wdata <= d;
        s_axi_wstrb <= s;
        s_axi_bready <= 1'b1;
        do begin
            @(posedge clk_i);
            if (s_axi_awvalid && s_axi_awready) s_axi_awvalid <= 1'b0;
            if (s_axi_wvalid && s_axi_wready) s_axi_wvalid <= 1'b0;
        end while (s_axi_awvalid || s_axi_wvalid);
        do @(posedge clk_i); while (!s_axi_bvalid);
        s_axi_bready <= 1'b0;
    endtask

    task automatic rd(input logic [31:0] a, input logic [33:0] e);
        int w;
        w = $urandom_range(2);
        exp_q.push_back(e);
        @(posedge clk_i);
        s_axi_arvalid <= 1'b1;
        s_axi_araddr <= a;
        do @(posedge clk_i); while (!(s_axi_arvalid && s_axi_arready));
        s_axi_arvalid <= 1'b0;
        repeat (w) @(posedge clk_i);
        s_axi_rready <= 1'b1;
        do @(posedge clk_i); while (!(s_axi_rvalid && s_axi_rready));
        s_axi_rready <= 1'b0;
    endtask

    task automatic set_fields(input logic [31:0] fv);
        wr(A7, {30'h0, fv[1:0]}, 4'hf, `PRL_RESP_OKAY);
        wr(A8, {16'h0, fv[15:12], 2'b11, fv[11:2]}, 4'hf, `PRL_RESP_OKAY);
        wr(A9, {16'h0, fv[31:16]}, 4'hf, `PRL_RESP_OKAY);
    endtask

    task automatic check_irq(input logic [31:0] fv, input logic [15:0] rq);
        @(posedge clk_i);
        want <= rq;
        lag <= 2'($urandom_range(2));
        repeat (6) @(posedge clk_i);
        exp_q.push_back(exp_irq(fv, rq));
        look <= 1'b1;
        @(posedge clk_i);
        look <= 1'b0;
        rd(AST, {18'h0, rq & enabled(fv)});
    endtask

    // oldest note against each answer or arbitration sample
    always @(posedge clk_i) begin
        if (look || (s_axi_rvalid && s_axi_rready) || (s_axi_bvalid && s_axi_bready)) begin
            if (exp_q.size() == 0) begin
                failures++;
                $display("mismatch %0t answer without note", $time);
            end else begin
                nx = exp_q.pop_front();
                if (look) `CHK({24'h0, irq_valid_o, irq_source_o, irq_level_o, level_active_o}, nx)
                else if (s_axi_rvalid) `CHK({s_axi_rresp, s_axi_rdata}, nx)
                else `CHK({s_axi_bresp, 32'h0}, nx)
            end
        end
    end

    // hang guard
    always @(posedge clk_i) begin
        cyc++;
        if (cyc == 40000) begin
            failures++;
            $display("mismatch %0t run too long", $time);
            final_report;
        end
    end

    task automatic final_report;
        $display("checks %0d mismatches %0d", samples_checked, failures);
        if (failures == 0 && samples_checked > 0) $display("STATUS OK");
        else $display("STATUS NOT OK");
        $finish;
    endtask

    // ----
    // main sequence
    // ----
    initial begin
        logic [31:0] fv;
        logic [31:0] d;
        logic [15:0] nv;
        logic [3:0] s;
        int k;
        void'($urandom(22614));
        repeat (5) @(posedge clk_i);
        rst_n_i <= 1'b1;
        repeat (4) @(posedge clk_i);
        for (k = 0; k < 3; k++) rd(ad[k], 34'h0);
        check_irq(32'h0, 16'hffff);
        $display("test reset values done");
        for (int i = 0; i < 9; i++) begin
            k = i % 3;
            d = $urandom;
            s = 4'($urandom_range(15));
            nv = cur[k];
            if (s[0]) nv[7:0] = d[7:0];
            if (s[1]) nv[15:8] = d[15:8];
            cur[k] = nv & msk[k];
            wr(ad[k], d, s, `PRL_RESP_OKAY);
            rd(ad[k], {18'h0, cur[k]});
        end
        $display("test readback done");
        wr(32'h28, $urandom, 4'hf, `PRL_RESP_SLVERR);
        rd(32'h28, {`PRL_RESP_SLVERR, 32'h0});
        rd(A8 + 32'h1, {`PRL_RESP_SLVERR, 32'h0});
        $display("test unmapped done");
        for (int n = 0; n < 16; n++) begin
            for (int c = 0; c < 4; c++) begin
                fv = 32'h0;
                fv[2*n +: 2] = c[1:0];
                set_fields(fv);
                check_irq(fv, 16'($urandom) | (16'h1 << n));
            end
        end
        $display("test field sweep done");
        for (int i = 0; i < 30; i++) begin
            fv = $urandom;
            set_fields(fv);
            rd(A8, {18'h0, fv[15:12], 2'b00, fv[11:2]});
            rd(A9, {18'h0, fv[31:16]});
            check_irq(fv, 16'($urandom));
        end
        $display("test arbitration done");
        rst_n_i <= 1'b0;
        repeat (5) @(posedge clk_i);
        rst_n_i <= 1'b1;
        repeat (4) @(posedge clk_i);
        for (k = 0; k < 3; k++) rd(ad[k], 34'h0);
        check_irq(32'h0, 16'hffff);
        $display("test mid-run reset done");
        final_report;
    end
endmodule // tb_top

`default_nettype wire
